// File: src/fan_pwm_acoustic_smoothing.sv
// Functional notes
// - ramp code limits remote one duty slew
// - fast table steps 1..48, 37.5s to 0.8s
// - slow table 52.2s down to 1.1s
// - smoothing only while enable bit set
// - sync set ties sense b,c,d to c
// - sync clear ties only sense c,d
// - drive a below threshold: off or minimum
// - drive b below threshold: off or minimum
// - drive c below threshold: off or minimum
// - lock bit makes register read-only
// - single remote one slow bit divides rate by four
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_acoustic_smoothing
	import fan_smooth_pkg::*;
#(
	parameter int unsigned FAST_TICK_CYCLES = int'(FAST_TICK),
	parameter int unsigned SLOW_TICK_CYCLES = int'(SLOW_TICK)
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// classic wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// duty computation engine
	input  wire logic [7:0]  target_duty_a,
	input  wire logic [7:0]  target_duty_b,
	input  wire logic [7:0]  target_duty_c,
	input  wire logic [2:0]  below_threshold,
	// fan drive outputs
	output logic             fan_drive_a,
	output logic             fan_drive_b,
	output logic             fan_drive_c,
	// speed-sense synchronisation to drive c
	output logic             speed_sense_b_sync_c,
	output logic             speed_sense_c_sync_c,
	output logic             speed_sense_d_sync_c
);

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	logic [7:0] acoustic_ramp_config_one;  // ramp, enable, sync, hold
	logic [7:0] config_six;                // slow table and quarter
	logic       lock;                      // sticky until reset
	logic [7:0] min_duty [DRIVES];         // hold level per drive
	logic [7:0] drive_ctrl;                // auto mode and owner

	logic [7:0] next_ramp_config;
	logic [7:0] next_config_six;
	logic       next_lock;
	logic [7:0] next_min_duty [DRIVES];
	logic [7:0] next_drive_ctrl;

	// bus signals
	logic [7:0]  index;        // word index from byte address
	logic        access;       // new request this cycle
	logic        wr;           // write strobe with low lane
	logic [31:0] next_dat;
	logic        next_ack;

	// per-drive datapath
	logic [7:0] present [DRIVES];  // ramped duty
	logic [7:0] target  [DRIVES];  // engine request
	logic [7:0] goal    [DRIVES];  // after below-threshold choice
	logic       next_drive [DRIVES];
	logic       drive_pin  [DRIVES];

	// sync outputs
	logic next_sense_b;
	logic next_sense_c;
	logic next_sense_d;

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	assign index  = wb_adr_i[9:2];
	// ack is dropped for one cycle after each answer
	assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// registers are eight bits wide so only lane zero writes them
	assign wr     = access && wb_we_i && wb_sel_i[0];

	// next register values and read data
	always_comb begin
		next_ramp_config = acoustic_ramp_config_one;
		next_config_six = config_six;
		next_lock = lock;
		next_drive_ctrl = drive_ctrl;
		for (int i = 0; i < DRIVES; i++) begin
			next_min_duty[i] = min_duty[i];
		end
		next_dat = 32'h00000000;
		next_ack = access;
		if (wr) begin
			if (index == IDX_RAMP_CONFIG_ONE) begin
				// writes are dropped once locked
				if (!lock) begin
					next_ramp_config = wb_dat_i[7:0];
				end
			end else if (index == IDX_CONFIG_SIX) begin
				next_config_six = wb_dat_i[7:0];
			end else if (index == IDX_CONFIG_ONE) begin
				// lock can be set but only reset clears it
				next_lock = lock | wb_dat_i[LOCK_BIT];
			end else if (index == IDX_MIN_DUTY_A) begin
				if (!lock) begin
					next_min_duty[0] = wb_dat_i[7:0];
				end
			end else if (index == IDX_MIN_DUTY_B) begin
				if (!lock) begin
					next_min_duty[1] = wb_dat_i[7:0];
				end
			end else if (index == IDX_MIN_DUTY_C) begin
				if (!lock) begin
					next_min_duty[2] = wb_dat_i[7:0];
				end
			end else if (index == IDX_DRIVE_CTRL) begin
				next_drive_ctrl = wb_dat_i[7:0];
			end
			// unmapped writes are acknowledged and ignored
		end
		if (access && !wb_we_i) begin
			if (index == IDX_RAMP_CONFIG_ONE) begin
				next_dat = {24'h000000, acoustic_ramp_config_one};
			end else if (index == IDX_CONFIG_SIX) begin
				next_dat = {24'h000000, config_six};
			end else if (index == IDX_CONFIG_ONE) begin
				next_dat = 32'(lock) << LOCK_BIT;
			end else if (index == IDX_MIN_DUTY_A) begin
				next_dat = {24'h000000, min_duty[0]};
			end else if (index == IDX_MIN_DUTY_B) begin
				next_dat = {24'h000000, min_duty[1]};
			end else if (index == IDX_MIN_DUTY_C) begin
				next_dat = {24'h000000, min_duty[2]};
			end else if (index == IDX_DRIVE_CTRL) begin
				next_dat = {24'h000000, drive_ctrl};
			end else if (index == IDX_DUTY_STATUS) begin
				// live duties let software watch a ramp in progress
				next_dat = {8'h00, present[2], present[1], present[0]};
			end
			// unmapped reads return zero
		end
	end

	// register file and bus answer
	always_ff @(posedge clock) begin
		if (rst) begin
			acoustic_ramp_config_one <= RST_RAMP_CONFIG;
			config_six <= RST_CONFIG_SIX;
			lock <= 1'b0;
			drive_ctrl <= RST_DRIVE_CTRL;
			for (int i = 0; i < DRIVES; i++) begin
				min_duty[i] <= RST_MIN_DUTY;
			end
			wb_dat_o <= 32'h00000000;
			wb_ack_o <= 1'b0;
		end else begin
			acoustic_ramp_config_one <= next_ramp_config;
			config_six <= next_config_six;
			lock <= next_lock;
			drive_ctrl <= next_drive_ctrl;
			for (int i = 0; i < DRIVES; i++) begin
				min_duty[i] <= next_min_duty[i];
			end
			wb_dat_o <= next_dat;
			wb_ack_o <= next_ack;
		end
	end

	// ---------------------------------------------------------------
	// ramp rate
	// ---------------------------------------------------------------
	logic                ramp_tick;  // one step of the slew
	logic [STEP_W-1:0]   ramp_step;  // duty change per step
	logic [2:0]          ramp_code;
	logic                smooth_enable_r1;

	assign ramp_code = acoustic_ramp_config_one[RAMP_CODE_LSB +: 3];
	assign smooth_enable_r1 = acoustic_ramp_config_one[SMOOTH_EN_BIT];
	// code picks the step size; the tick period sets the table
	assign ramp_step = STEP_TABLE[ramp_code * STEP_W +: STEP_W];

	// step period: fast or slow table, optionally four times longer
	ramp_tick_gen #(
		.FAST_CYCLES (FAST_TICK_CYCLES),
		.SLOW_CYCLES (SLOW_TICK_CYCLES)
	) u_tick (
		.clock    (clock),
		.rst      (rst),
		.slow_sel (config_six[SLOW_TABLE_BIT]),
		.quarter  (config_six[QUARTER_BIT]),
		.tick     (ramp_tick)
	);

	// ---------------------------------------------------------------
	// pwm period counter
	// ---------------------------------------------------------------
	logic [7:0] pwm_div;        // prescaler for the pwm counter
	logic [7:0] pwm_count;      // position within the pwm period
	logic [7:0] next_pwm_div;
	logic [7:0] next_pwm_count;

	always_comb begin
		next_pwm_div = pwm_div + 8'h01;
		next_pwm_count = pwm_count;
		if (pwm_div == PWM_DIV - 8'h01) begin
			next_pwm_div = 8'h00;
			next_pwm_count = pwm_count + 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pwm_div <= 8'h00;
			pwm_count <= 8'h00;
		end else begin
			pwm_div <= next_pwm_div;
			pwm_count <= next_pwm_count;
		end
	end

	// ---------------------------------------------------------------
	// per-drive target selection, slew and pwm
	// ---------------------------------------------------------------
	assign target[0] = target_duty_a;
	assign target[1] = target_duty_b;
	assign target[2] = target_duty_c;

	for (genvar d = 0; d < DRIVES; d++) begin : g_drive
		logic hold;      // keep minimum duty below threshold
		logic auto_mode;
		logic owner_r1;  // drive follows remote one channel

		// bits 5,6,7 serve drives a,b,c in order
		assign hold      = acoustic_ramp_config_one[HOLD_LSB + d];
		assign auto_mode = drive_ctrl[AUTO_LSB + d];
		assign owner_r1  = drive_ctrl[ASSOC_LSB + d];

		// below threshold minus hysteresis: off or minimum duty
		always_comb begin
			goal[d] = target[d];
			if (auto_mode && below_threshold[d]) begin
				goal[d] = hold ? min_duty[d] : DUTY_OFF;
			end
		end

		// only drives owned by remote one are rate limited
		duty_ramp u_ramp (
			.clock    (clock),
			.rst      (rst),
			.limit_en (owner_r1 && smooth_enable_r1),
			.step_en  (ramp_tick),
			.step     (ramp_step),
			.goal     (goal[d]),
			.duty     (present[d])
		);

		// full scale forces the pin high for the whole period
		always_comb begin
			next_drive[d] = (present[d] == DUTY_MAX) ||
				(pwm_count < present[d]);
		end

		always_ff @(posedge clock) begin
			if (rst) begin
				drive_pin[d] <= 1'b0;
			end else begin
				drive_pin[d] <= next_drive[d];
			end
		end
	end

	assign fan_drive_a = drive_pin[0];
	assign fan_drive_b = drive_pin[1];
	assign fan_drive_c = drive_pin[2];

	// ---------------------------------------------------------------
	// speed-sense synchronisation selects
	// ---------------------------------------------------------------
	always_comb begin
		// sense b joins drive c only with sync set
		next_sense_b = acoustic_ramp_config_one[SYNC_SEL_BIT];
		// sense c and d always follow drive c
		next_sense_c = 1'b1;
		next_sense_d = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			speed_sense_b_sync_c <= 1'b0;
			speed_sense_c_sync_c <= 1'b0;
			speed_sense_d_sync_c <= 1'b0;
		end else begin
			speed_sense_b_sync_c <= next_sense_b;
			speed_sense_c_sync_c <= next_sense_c;
			speed_sense_d_sync_c <= next_sense_d;
		end
	end

endmodule // fan_pwm_acoustic_smoothing
`default_nettype wire

// File: src/fan_smooth_pkg.sv
package fan_smooth_pkg;

	// ---------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [7:0] IDX_CONFIG_SIX      = 8'h10;
	localparam logic [7:0] IDX_CONFIG_ONE      = 8'h40;
	localparam logic [7:0] IDX_RAMP_CONFIG_ONE = 8'h62;
	localparam logic [7:0] IDX_MIN_DUTY_A      = 8'h64;
	localparam logic [7:0] IDX_MIN_DUTY_B      = 8'h65;
	localparam logic [7:0] IDX_MIN_DUTY_C      = 8'h66;
	localparam logic [7:0] IDX_DRIVE_CTRL      = 8'h70;
	localparam logic [7:0] IDX_DUTY_STATUS     = 8'h71;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_RAMP_CONFIG = 8'h00;
	localparam logic [7:0] RST_CONFIG_SIX  = 8'h00;
	localparam logic [7:0] RST_MIN_DUTY    = 8'h80;
	localparam logic [7:0] RST_DRIVE_CTRL  = 8'h0F;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int RAMP_CODE_LSB  = 0;   // ramp code [2:0]
	localparam int SMOOTH_EN_BIT  = 3;
	localparam int SYNC_SEL_BIT   = 4;
	localparam int HOLD_LSB       = 5;   // hold bits [7:5]
	localparam int LOCK_BIT       = 0;   // lock in config one
	localparam int QUARTER_BIT    = 0;   // remote one slow-by-four
	localparam int SLOW_TABLE_BIT = 7;   // slow ramp table select
	localparam int AUTO_LSB       = 0;   // per-drive automatic mode
	localparam int ASSOC_LSB      = 3;   // per-drive remote one owner

	// ---------------------------------------------------------------
	// duty step per ramp code, six bits each, code 0 lowest
	// ---------------------------------------------------------------
	localparam logic [47:0] STEP_TABLE =
		{6'd48, 6'd24, 6'd12, 6'd8, 6'd4, 6'd3, 6'd2, 6'd1};
	localparam int STEP_W = 6;

	// ---------------------------------------------------------------
	// timing: full-scale ramp time at step one, in milliseconds
	// ---------------------------------------------------------------
	localparam longint CLOCK_KHZ       = 64'd200000;
	localparam longint FULL_FAST_MS    = 64'd37500;
	localparam longint FULL_SLOW_MS    = 64'd52200;
	localparam longint FULL_SCALE_DUTY = 64'd255;
	localparam longint FAST_TICK =
		(FULL_FAST_MS * CLOCK_KHZ) / FULL_SCALE_DUTY;
	localparam longint SLOW_TICK =
		(FULL_SLOW_MS * CLOCK_KHZ) / FULL_SCALE_DUTY;
	localparam int QUARTER_FACTOR = 4;

	// pwm counter advances once per this many clocks
	localparam logic [7:0] PWM_DIV  = 8'h40;
	localparam logic [7:0] DUTY_MAX = 8'hFF;
	localparam logic [7:0] DUTY_OFF = 8'h00;
	localparam int         DRIVES   = 3;

endpackage

// File: src/ramp_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
module ramp_tick_gen
	import fan_smooth_pkg::*;
#(
	parameter int unsigned FAST_CYCLES = 1000,
	parameter int unsigned SLOW_CYCLES = 1400
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// rate selection
	input  wire logic slow_sel,
	input  wire logic quarter,
	// one-cycle step enable
	output logic      tick
);

	// ---------------------------------------------------------------
	// period select
	// ---------------------------------------------------------------
	logic [31:0] base;        // step period before division
	logic [31:0] period;      // final step period
	logic [31:0] count;       // cycles since last tick
	logic [31:0] next_count;
	logic        next_tick;

	// a change of rate takes effect at once, so a step lands early
	// when software switches to a period the count has already passed
	always_comb begin
		base = slow_sel ? SLOW_CYCLES : FAST_CYCLES;
		period = quarter ? 32'(base * QUARTER_FACTOR) : base;
		next_tick = 1'b0;
		next_count = count + 32'h00000001;
		if (count + 32'h00000001 >= period) begin
			next_count = 32'h00000000;
			next_tick = 1'b1;
		end
	end

	// registers only
	always_ff @(posedge clock) begin
		if (rst) begin
			count <= 32'h00000000;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end

endmodule // ramp_tick_gen
`default_nettype wire

// File: src/duty_ramp.sv
`timescale 1ns/10ps
`default_nettype none
module duty_ramp
	import fan_smooth_pkg::*;
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// rate control
	input  wire logic              limit_en,
	input  wire logic              step_en,
	input  wire logic [STEP_W-1:0] step,
	// target and present duty
	input  wire logic [7:0]        goal,
	output logic [7:0]             duty
);

	// ---------------------------------------------------------------
	// slew toward goal
	// ---------------------------------------------------------------
	logic [7:0] next_duty;
	logic [8:0] up;       // one bit wider so saturation is visible
	logic [8:0] down;

	always_comb begin
		up = {1'b0, duty} + {3'b000, step};
		down = {1'b0, duty} - {3'b000, step};
		next_duty = duty;
		if (!limit_en) begin
			// no smoothing: jump straight to the target
			next_duty = goal;
		end else if (step_en) begin
			// never overshoot: clamp the last step to the goal
			if (goal > duty) begin
				next_duty = (up > {1'b0, goal}) ? goal : up[7:0];
			end else if (goal < duty) begin
				next_duty = (down[8] || down < {1'b0, goal}) ?
					goal : down[7:0];
			end
		end
	end

	// registers only
	always_ff @(posedge clock) begin
		if (rst) begin
			duty <= DUTY_OFF;
		end else begin
			duty <= next_duty;
		end
	end

endmodule // duty_ramp
`default_nettype wire

// File: verification/fan_smooth_checker.sv
`timescale 1ns/10ps
`default_nettype none
module fan_smooth_checker
	import fan_smooth_pkg::*;
(
	// clock and reset
	input wire logic        clock,
	input wire logic        rst,
	// register bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [9:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// engine side and pins
	input wire logic [7:0]  target_duty_b,
	input wire logic [2:0]  below_threshold,
	input wire logic        fan_drive_a,
	input wire logic        fan_drive_b,
	input wire logic        fan_drive_c,
	input wire logic        speed_sense_b_sync_c,
	input wire logic        speed_sense_c_sync_c,
	input wire logic        speed_sense_d_sync_c
);
	// ------------------------------------
	// shadow of the bits the pins follow
	// ------------------------------------
	logic       take;       // write accepted at this edge
	logic [7:0] ramp;       // ramp config copy
	logic [2:0] autom;      // automatic mode copy
	logic       lock;       // sticky lock copy
	logic [7:0] next_ramp;
	logic [2:0] next_autom;
	logic       next_lock;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
	// lock guards the ramp copy, drive control is never locked
	always_comb begin
		next_ramp = ramp;
		next_autom = autom;
		next_lock = lock;
		if (take && wb_adr_i[9:2] == IDX_RAMP_CONFIG_ONE && !lock) begin
			next_ramp = wb_dat_i[7:0];
		end
		if (take && wb_adr_i[9:2] == IDX_DRIVE_CTRL) begin
			next_autom = wb_dat_i[2:0];
		end
		if (take && wb_adr_i[9:2] == IDX_CONFIG_ONE) begin
			next_lock = lock | wb_dat_i[LOCK_BIT];
		end
	end
	// register the copies
	always_ff @(posedge clock) begin
		if (rst) begin
			ramp <= RST_RAMP_CONFIG;
			autom <= RST_DRIVE_CTRL[2:0];
			lock <= 1'b0;
		end else begin
			ramp <= next_ramp;
			autom <= next_autom;
			lock <= next_lock;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ------------------------------------
	// bus handshake
	// ------------------------------------
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	a_ack_answers: assert property
		((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_read_upper_zero: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o
		&& !wb_we_i && wb_adr_i[9:2] != IDX_DUTY_STATUS)
		|=> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	// ------------------------------------
	// speed-sense synchronisation
	// ------------------------------------
	a_sense_cd_tied: assert property
		(!rst |=> speed_sense_c_sync_c && speed_sense_d_sync_c)
		else $error("sense c or d not tied to drive c");
	a_sense_b_follow: assert property
		(ramp[SYNC_SEL_BIT] == $past(ramp[SYNC_SEL_BIT])
		|-> speed_sense_b_sync_c == ramp[SYNC_SEL_BIT])
		else $error("sense b does not follow sync bit");
	// ------------------------------------
	// below threshold with hold clear means off, full target means on
	// ------------------------------------
	a_drive_a_off: assert property
		((below_threshold[0] && autom[0] && !ramp[HOLD_LSB]
		&& !ramp[SMOOTH_EN_BIT])[*4] |-> !fan_drive_a)
		else $error("drive a not off below threshold");
	a_drive_b_off: assert property
		((below_threshold[1] && autom[1] && !ramp[HOLD_LSB+1]
		&& !ramp[SMOOTH_EN_BIT])[*4] |-> !fan_drive_b)
		else $error("drive b not off below threshold");
	a_drive_c_off: assert property
		((below_threshold[2] && autom[2] && !ramp[HOLD_LSB+2]
		&& !ramp[SMOOTH_EN_BIT])[*4] |-> !fan_drive_c)
		else $error("drive c not off below threshold");
	a_drive_b_full: assert property
		((!below_threshold[1] && target_duty_b == DUTY_MAX
		&& !ramp[SMOOTH_EN_BIT])[*4] |-> fan_drive_b)
		else $error("drive b not full at full target");
endmodule // fan_smooth_checker
bind fan_pwm_acoustic_smoothing fan_smooth_checker u_fan_smooth_checker (
	.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .target_duty_b, .below_threshold,
	.fan_drive_a, .fan_drive_b, .fan_drive_c, .speed_sense_b_sync_c,
	.speed_sense_c_sync_c, .speed_sense_d_sync_c
);
`default_nettype wire

// File: verification/fan_model.sv
`timescale 1ns/10ps
`default_nettype none
module fan_model (
	// clock and restart of the measurement
	input wire logic   clock,
	input wire logic   clear,
	// drive pin from the controller
	input wire logic   drive,
	// high cycles seen since the last clear
	output logic [15:0] high_count
);
	// a fan only integrates its drive, so count high cycles
	always_ff @(posedge clock) begin
		if (clear) begin
			high_count <= 16'h0000;
		end else if (drive) begin
			high_count <= high_count + 16'h0001;
		end
	end
endmodule // fan_model
`default_nettype wire

// File: verification/fan_pwm_acoustic_smoothing_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_acoustic_smoothing_tb_top
	import fan_smooth_pkg::*;
;
	// short tick periods keep the ramp runs brief
	localparam int FAST = 20;
	localparam int SLOW = 28;
	logic        clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [9:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [7:0]  target_duty_a, target_duty_b, target_duty_c;
	logic [7:0]  ma, mb, mc, prev;
	logic [2:0]  below_threshold, h;
	logic        fan_drive_a, fan_drive_b, fan_drive_c, clear;
	logic        speed_sense_b_sync_c, speed_sense_c_sync_c;
	logic        speed_sense_d_sync_c;
	logic [15:0] high_a, high_b, high_c;
	logic [4:0]  kk;
	int          err_count, n_checks, cnt, per, seen, n, t0;
	fan_pwm_acoustic_smoothing #(
		.FAST_TICK_CYCLES(FAST),
		.SLOW_TICK_CYCLES(SLOW)
	) u_fan_pwm_acoustic_smoothing (
		.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .target_duty_a,
		.target_duty_b, .target_duty_c, .below_threshold, .fan_drive_a,
		.fan_drive_b, .fan_drive_c, .speed_sense_b_sync_c,
		.speed_sense_c_sync_c, .speed_sense_d_sync_c
	);
	fan_model u_fan_model_a (.clock, .clear, .drive(fan_drive_a),
		.high_count(high_a));
	fan_model u_fan_model_b (.clock, .clear, .drive(fan_drive_b),
		.high_count(high_b));
	fan_model u_fan_model_c (.clock, .clear, .drive(fan_drive_c),
		.high_count(high_c));
	// 200 MHz clock and a free cycle count
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) cnt <= cnt + 1;
	// ------------------------------------
	// expectations and checking
	// ------------------------------------
	function automatic int step_of(input int c);
		int t[8] = '{1, 2, 3, 4, 8, 12, 24, 48};
		return t[c];
	endfunction
	// full duty holds the pin high, else 64 clocks per duty count
	function automatic logic [15:0] high_of(input logic [7:0] d);
		return (d == 8'hFF) ? 16'h4000 : {2'b00, d, 6'h00};
	endfunction
	task automatic check(input logic [31:0] seen_v, input logic [31:0] exp);
		n_checks++;
		if (seen_v !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic give_up();
		err_count++;
		complete_run();
	endtask
	// one classic cycle, held until ack, then one idle cycle
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [7:0] d, input logic [3:0] sel);
		int k;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= sel;
		wb_dat_i <= {24'h000000, d};
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		if (k >= 20) give_up();
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 8'h00, 4'hF);
		check(rd, exp);
	endtask
	// ------------------------------------
	// main sequence
	// ------------------------------------
	initial begin
		void'($urandom(55));
		{rst, clear} = 2'b11;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		{target_duty_a, target_duty_b, target_duty_c} = '0;
		below_threshold = 3'h0;
		{err_count, n_checks} = 0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		// reset values, unmapped reads zero
		rd_chk(IDX_RAMP_CONFIG_ONE, 32'h00);
		rd_chk(IDX_CONFIG_SIX, 32'h00);
		for (int i = 0; i < 3; i++) rd_chk(IDX_MIN_DUTY_A + 8'(i), 32'h80);
		rd_chk(IDX_DRIVE_CTRL, 32'h0F);
		rd_chk(8'h7F, 32'h00);
		// smoothing off: targets pass at once, full first
		for (int j = 0; j < 16; j++) begin
			target_duty_a <= (j == 0) ? 8'hFF : 8'($urandom);
			target_duty_b <= (j == 0) ? 8'hFF : 8'($urandom);
			target_duty_c <= (j == 0) ? 8'hFF : 8'($urandom);
			repeat (5) @(posedge clock);
			rd_chk(IDX_DUTY_STATUS, {8'h00, target_duty_c, target_duty_b,
				target_duty_a});
		end
		target_duty_a <= 8'h10;
		target_duty_b <= 8'h40;
		target_duty_c <= 8'hFF;
		repeat (3) @(posedge clock);
		clear <= 1'b0;
		// the count made at the reading edge is not yet visible, so one
		// edge more gives exactly one whole pwm period of samples
		repeat (16385) @(posedge clock);
		check(high_a, high_of(8'h10));
		check(high_b, high_of(8'h40));
		check(high_c, high_of(8'hFF));
		// below threshold: every hold combination with random minimums
		{ma, mb, mc} = {8'($urandom), 8'($urandom), 8'($urandom)};
		bus(1'b1, IDX_MIN_DUTY_A, ma, 4'hF);
		bus(1'b1, IDX_MIN_DUTY_B, mb, 4'hF);
		bus(1'b1, IDX_MIN_DUTY_C, mc, 4'hF);
		below_threshold <= 3'h7;
		for (int j = 0; j < 8; j++) begin
			h = 3'(j);
			bus(1'b1, IDX_RAMP_CONFIG_ONE, {h, h[0] ^ h[1], 4'h0}, 4'hF);
			repeat (4) @(posedge clock);
			rd_chk(IDX_DUTY_STATUS, {8'h00, h[2] ? mc : 8'h00,
				h[1] ? mb : 8'h00, h[0] ? ma : 8'h00});
			check(speed_sense_b_sync_c, h[0] ^ h[1]);
			check(speed_sense_c_sync_c & speed_sense_d_sync_c, 1'b1);
		end
		below_threshold <= 3'h0;
		// smoothing on: each table, quarter rate and code
		for (int k = 0; k < 32; k++) begin
			kk = 5'(k);
			bus(1'b1, IDX_RAMP_CONFIG_ONE, 8'h00, 4'hF);
			target_duty_a <= 8'h00;
			bus(1'b1, IDX_CONFIG_SIX, {kk[4], 6'h00, kk[3]}, 4'hF);
			bus(1'b1, IDX_RAMP_CONFIG_ONE, {5'h01, kk[2:0]}, 4'hF);
			target_duty_a <= 8'hFF;
			per = (kk[4] ? SLOW : FAST) * (kk[3] ? 4 : 1);
			{prev, seen, n} = 0;
			while (seen < 3 && n < 1000) begin
				bus(1'b0, IDX_DUTY_STATUS, 8'h00, 4'hF);
				n++;
				if (rd[7:0] != prev) begin
					check(rd[7:0] - prev, 8'(step_of(kk[2:0])));
					if (seen == 2) check(cnt - t0 >= per - 2
						&& cnt - t0 <= per + 2, 1'b1);
					seen++;
					t0 = cnt;
					prev = rd[7:0];
				end
			end
			if (seen < 3) give_up();
		end
		// no automatic mode and no owner: targets pass despite both
		bus(1'b1, IDX_DRIVE_CTRL, 8'h00, 4'hF);
		below_threshold <= 3'h7;
		{target_duty_a, target_duty_b} <= {8'($urandom), 8'($urandom)};
		repeat (4) @(posedge clock);
		rd_chk(IDX_DRIVE_CTRL, 32'h00);
		rd_chk(IDX_DUTY_STATUS, {8'h00, target_duty_c, target_duty_b,
			target_duty_a});
		// byte lane off, unmapped write, then lock
		bus(1'b1, IDX_CONFIG_SIX, 8'h55, 4'hE);
		rd_chk(IDX_CONFIG_SIX, 32'h81);
		bus(1'b1, 8'h7E, 8'hA5, 4'hF);
		rd_chk(8'h7E, 32'h00);
		bus(1'b1, IDX_CONFIG_ONE, 8'h01, 4'hF);
		bus(1'b1, IDX_RAMP_CONFIG_ONE, 8'($urandom), 4'hF);
		rd_chk(IDX_RAMP_CONFIG_ONE, 32'h0F);
		bus(1'b1, IDX_MIN_DUTY_A, ~ma, 4'hF);
		rd_chk(IDX_MIN_DUTY_A, {24'h000000, ma});
		bus(1'b1, IDX_CONFIG_SIX, 8'h80, 4'hF);
		rd_chk(IDX_CONFIG_SIX, 32'h80);
		complete_run();
	end
endmodule // fan_pwm_acoustic_smoothing_tb_top
`default_nettype wire
